//--- verilog/pin_clear_pkg.sv
package pin_clear_pkg;

    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;

    // register byte offsets
    localparam logic [7:0] FUNC_OFFSET    = 8'h10;
    localparam logic [7:0] DIR_OFFSET     = 8'h14;
    localparam logic [7:0] OUT_OFFSET     = 8'h18;
    localparam logic [7:0] CLR_OFFSET     = 8'h20;
    localparam logic [7:0] ADDR_WORD_MASK = 8'hFC;

    // field layout and reset value
    localparam logic [31:0] IMPL_MASK = 32'hFE00_FFFF;
    localparam logic [31:0] RSVD_MASK = 32'h01FF_0000;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    localparam logic [31:0] ALL_ZERO  = 32'h0000_0000;
    localparam logic [31:0] ALL_ONES  = 32'hFFFF_FFFF;

    // pin bit positions
    localparam int RX_FRAME_SYNC_BIT = 31;
    localparam int RX_HIGH_CLOCK_BIT = 30;
    localparam int RX_BIT_CLOCK_BIT  = 29;
    localparam int TX_FRAME_SYNC_BIT = 28;
    localparam int TX_HIGH_CLOCK_BIT = 27;
    localparam int TX_BIT_CLOCK_BIT  = 26;
    localparam int MUTE_BIT          = 25;
    localparam int SERIAL_DATA_MSB   = 15;
    localparam int SERIAL_DATA_LSB   = 0;
    localparam int BYTE_BITS         = 8;

    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // software visible pin state
    typedef struct packed {
        logic [31:0] func;
        logic [31:0] dir;
        logic [31:0] out;
    } pin_regs_t;

    // one write as seen by the register file
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] data;
        logic [3:0]  strb;
    } wr_req_t;

    typedef enum logic [1:0] {
        W_IDLE = 2'h1,
        W_RESP = 2'h2
    } wr_state_t;

    typedef enum logic [1:0] {
        R_IDLE = 2'h1,
        R_DATA = 2'h2
    } rd_state_t;

endpackage : pin_clear_pkg

//--- verilog/reg_bit_update.sv
`timescale 1ns/1ns
module reg_bit_update #(
    parameter int WIDTH = 32
) (
    // current value and write request
    input  wire logic [WIDTH-1:0]   cur,
    input  wire logic               write_en,
    input  wire logic               clear_en,
    input  wire logic [WIDTH-1:0]   data,
    input  wire logic [WIDTH/8-1:0] strb,
    input  wire logic [WIDTH-1:0]   mask,
    // resulting value
    output logic      [WIDTH-1:0]   next
);

    // per bit: a plain write stores, a clear write zeroes the ones, else hold
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic lane;
            assign lane = strb[i/pin_clear_pkg::BYTE_BITS];
            always_comb begin
                if (!mask[i]) begin
                    next[i] = 1'b0;
                end else if (clear_en && lane && data[i]) begin
                    next[i] = 1'b0;
                end else if (write_en && lane) begin
                    next[i] = data[i];
                end else begin
                    next[i] = cur[i];
                end
            end
        end
    endgenerate

endmodule : reg_bit_update

//--- verilog/pin_driver.sv
`timescale 1ns/1ns
module pin_driver #(
    parameter int WIDTH = 32
) (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    // pin state from the register file
    input  wire pin_clear_pkg::pin_regs_t  regs,
    // pad side
    output logic      [WIDTH-1:0]          pin_out,
    output logic      [WIDTH-1:0]          pin_oe_n
);

    logic [WIDTH-1:0] next_pin_out;
    logic [WIDTH-1:0] next_pin_oe_n;

    // a pin is driven only when set to general purpose and output
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_pin
            always_comb begin
                next_pin_out[i]  = regs.out[i];
                next_pin_oe_n[i] = !(regs.func[i] && regs.dir[i]
                                     && pin_clear_pkg::IMPL_MASK[i]);
            end
        end
    endgenerate

    // pad registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_out  <= pin_clear_pkg::ALL_ZERO;
            pin_oe_n <= pin_clear_pkg::ALL_ONES;
        end else begin
            pin_out  <= next_pin_out;
            pin_oe_n <= next_pin_oe_n;
        end
    end

endmodule : pin_driver

//--- verilog/pin_output_clear_alias.sv
// What this block does
// - clear address is write-only; writes act on output data, nothing stored.
// - each written one in a strobed byte zeroes its output data bit; zeros change nothing.
// - cleared bit of a general-purpose output pin drives that pin low.
// - unselected output bits and pins keep their present state.
// - bits 31 to 25 are frame sync, clocks and mute pins, in order.
// - bits 15 to 0 are serial data pins 15 to 0, one to one.
// - bits 24 to 16 read zero and writes there do nothing.
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ns
module pin_output_clear_alias (
    // clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        RST_N,
    // write address channel
    input  wire logic [7:0]  AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    // write data channel
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    // write response channel
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    // read address channel
    input  wire logic [7:0]  ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    // read data channel
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY,
    // pins
    output logic [31:0]      PIN_OUT,
    output logic [31:0]      PIN_OE_N
);

    // write side state
    pin_clear_pkg::wr_state_t wr_state;
    pin_clear_pkg::wr_state_t next_wr_state;
    logic                     aw_ready;
    logic                     next_aw_ready;
    logic                     w_ready;
    logic                     next_w_ready;
    logic                     aw_hold;
    logic                     next_aw_hold;
    logic                     w_hold;
    logic                     next_w_hold;
    logic [7:0]               aw_addr;
    logic [7:0]               next_aw_addr;
    logic [31:0]              w_data;
    logic [31:0]              next_w_data;
    logic [3:0]               w_strb;
    logic [3:0]               next_w_strb;
    logic                     b_valid;
    logic                     next_b_valid;
    logic [1:0]               b_resp;
    logic [1:0]               next_b_resp;

    // read side state
    pin_clear_pkg::rd_state_t rd_state;
    pin_clear_pkg::rd_state_t next_rd_state;
    logic                     ar_ready;
    logic                     next_ar_ready;
    logic                     r_valid;
    logic                     next_r_valid;
    logic [31:0]              r_data;
    logic [31:0]              next_r_data;
    logic [1:0]               r_resp;
    logic [1:0]               next_r_resp;

    // register file
    pin_clear_pkg::pin_regs_t regs;
    pin_clear_pkg::pin_regs_t next_regs;

    // decoded write
    pin_clear_pkg::wr_req_t   req;
    logic                     aw_fire;
    logic                     w_fire;
    logic                     ar_fire;
    logic                     wr_now;
    logic [7:0]               wr_word;
    logic [7:0]               rd_word;
    logic                     hit_func;
    logic                     hit_dir;
    logic                     hit_out;
    logic                     hit_clr;
    logic [31:0]              clr_mask;

    // handshakes and the write as it reaches the register file
    assign aw_fire  = AWVALID && aw_ready;
    assign w_fire   = WVALID && w_ready;
    assign ar_fire  = ARVALID && ar_ready;
    assign req.addr = aw_hold ? aw_addr : AWADDR;
    assign req.data = w_hold ? w_data : WDATA;
    assign req.strb = w_hold ? w_strb : WSTRB;
    assign wr_now   = (wr_state == pin_clear_pkg::W_IDLE)
                      && (aw_hold || aw_fire) && (w_hold || w_fire);
    assign wr_word  = req.addr & pin_clear_pkg::ADDR_WORD_MASK;
    assign rd_word  = ARADDR & pin_clear_pkg::ADDR_WORD_MASK;
    assign hit_func = (wr_word == pin_clear_pkg::FUNC_OFFSET);
    assign hit_dir  = (wr_word == pin_clear_pkg::DIR_OFFSET);
    assign hit_out  = (wr_word == pin_clear_pkg::OUT_OFFSET);
    assign hit_clr  = (wr_word == pin_clear_pkg::CLR_OFFSET);
    assign clr_mask = req.data & pin_clear_pkg::IMPL_MASK
                      & {{8{req.strb[3]}}, {8{req.strb[2]}},
                         {8{req.strb[1]}}, {8{req.strb[0]}}};

    // function and direction selects take plain writes
    reg_bit_update #(.WIDTH(pin_clear_pkg::DATA_W)) u_func (
        .cur      (regs.func),
        .write_en (wr_now && hit_func),
        .clear_en (1'b0),
        .data     (req.data),
        .strb     (req.strb),
        .mask     (pin_clear_pkg::IMPL_MASK),
        .next     (next_regs.func)
    );

    reg_bit_update #(.WIDTH(pin_clear_pkg::DATA_W)) u_dir (
        .cur      (regs.dir),
        .write_en (wr_now && hit_dir),
        .clear_en (1'b0),
        .data     (req.data),
        .strb     (req.strb),
        .mask     (pin_clear_pkg::IMPL_MASK),
        .next     (next_regs.dir)
    );

    // output data: plain writes, and clear writes through the alias
    reg_bit_update #(.WIDTH(pin_clear_pkg::DATA_W)) u_out (
        .cur      (regs.out),
        .write_en (wr_now && hit_out),
        .clear_en (wr_now && hit_clr),
        .data     (req.data),
        .strb     (req.strb),
        .mask     (pin_clear_pkg::IMPL_MASK),
        .next     (next_regs.out)
    );

    // register file update in the accepting cycle
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            regs.func <= pin_clear_pkg::REG_RESET;
            regs.dir  <= pin_clear_pkg::REG_RESET;
            regs.out  <= pin_clear_pkg::REG_RESET;
        end else begin
            regs <= next_regs;
        end
    end

    // write channel sequencing: address and data in either order
    always_comb begin
        next_wr_state = wr_state;
        next_aw_ready = aw_ready;
        next_w_ready  = w_ready;
        next_aw_hold  = aw_hold;
        next_w_hold   = w_hold;
        next_aw_addr  = aw_addr;
        next_w_data   = w_data;
        next_w_strb   = w_strb;
        next_b_valid  = b_valid;
        next_b_resp   = b_resp;
        unique case (wr_state)
            pin_clear_pkg::W_IDLE: begin
                if (wr_now) begin
                    next_wr_state = pin_clear_pkg::W_RESP;
                    next_aw_ready = 1'b0;
                    next_w_ready  = 1'b0;
                    next_aw_hold  = 1'b0;
                    next_w_hold   = 1'b0;
                    next_b_valid  = 1'b1;
                    next_b_resp   = (hit_func || hit_dir || hit_out || hit_clr)
                                    ? pin_clear_pkg::RESP_OKAY
                                    : pin_clear_pkg::RESP_SLVERR;
                end else begin
                    if (aw_fire) begin
                        next_aw_hold  = 1'b1;
                        next_aw_ready = 1'b0;
                        next_aw_addr  = AWADDR;
                    end
                    if (w_fire) begin
                        next_w_hold  = 1'b1;
                        next_w_ready = 1'b0;
                        next_w_data  = WDATA;
                        next_w_strb  = WSTRB;
                    end
                end
            end
            pin_clear_pkg::W_RESP: begin
                if (BREADY) begin
                    next_wr_state = pin_clear_pkg::W_IDLE;
                    next_b_valid  = 1'b0;
                    next_aw_ready = 1'b1;
                    next_w_ready  = 1'b1;
                end
            end
        endcase
    end

    // write channel registers
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            wr_state <= pin_clear_pkg::W_IDLE;
            aw_ready <= 1'b1;
            w_ready  <= 1'b1;
            aw_hold  <= 1'b0;
            w_hold   <= 1'b0;
            aw_addr  <= 8'h00;
            w_data   <= pin_clear_pkg::ALL_ZERO;
            w_strb   <= 4'h0;
            b_valid  <= 1'b0;
            b_resp   <= pin_clear_pkg::RESP_OKAY;
        end else begin
            wr_state <= next_wr_state;
            aw_ready <= next_aw_ready;
            w_ready  <= next_w_ready;
            aw_hold  <= next_aw_hold;
            w_hold   <= next_w_hold;
            aw_addr  <= next_aw_addr;
            w_data   <= next_w_data;
            w_strb   <= next_w_strb;
            b_valid  <= next_b_valid;
            b_resp   <= next_b_resp;
        end
    end

    // read channel: one cycle from address to data
    always_comb begin
        next_rd_state = rd_state;
        next_ar_ready = ar_ready;
        next_r_valid  = r_valid;
        next_r_data   = r_data;
        next_r_resp   = r_resp;
        unique case (rd_state)
            pin_clear_pkg::R_IDLE: begin
                if (ar_fire) begin
                    next_rd_state = pin_clear_pkg::R_DATA;
                    next_ar_ready = 1'b0;
                    next_r_valid  = 1'b1;
                    next_r_resp   = pin_clear_pkg::RESP_OKAY;
                    if (rd_word == pin_clear_pkg::FUNC_OFFSET) begin
                        next_r_data = regs.func & pin_clear_pkg::IMPL_MASK;
                    end else if (rd_word == pin_clear_pkg::DIR_OFFSET) begin
                        next_r_data = regs.dir & pin_clear_pkg::IMPL_MASK;
                    end else if (rd_word == pin_clear_pkg::OUT_OFFSET) begin
                        next_r_data = regs.out & pin_clear_pkg::IMPL_MASK;
                    end else if (rd_word == pin_clear_pkg::CLR_OFFSET) begin
                        next_r_data = pin_clear_pkg::ALL_ZERO;
                    end else begin
                        next_r_data = pin_clear_pkg::ALL_ZERO;
                        next_r_resp = pin_clear_pkg::RESP_SLVERR;
                    end
                end
            end
            pin_clear_pkg::R_DATA: begin
                if (RREADY) begin
                    next_rd_state = pin_clear_pkg::R_IDLE;
                    next_ar_ready = 1'b1;
                    next_r_valid  = 1'b0;
                end
            end
        endcase
    end

    // read channel registers
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            rd_state <= pin_clear_pkg::R_IDLE;
            ar_ready <= 1'b1;
            r_valid  <= 1'b0;
            r_data   <= pin_clear_pkg::ALL_ZERO;
            r_resp   <= pin_clear_pkg::RESP_OKAY;
        end else begin
            rd_state <= next_rd_state;
            ar_ready <= next_ar_ready;
            r_valid  <= next_r_valid;
            r_data   <= next_r_data;
            r_resp   <= next_r_resp;
        end
    end

    // pad drivers
    pin_driver #(.WIDTH(pin_clear_pkg::DATA_W)) u_pins (
        .clk      (CORE_CLK),
        .rst_n    (RST_N),
        .regs     (regs),
        .pin_out  (PIN_OUT),
        .pin_oe_n (PIN_OE_N)
    );

    // bus outputs straight from their registers
    assign AWREADY = aw_ready;
    assign WREADY  = w_ready;
    assign BVALID  = b_valid;
    assign BRESP   = b_resp;
    assign ARREADY = ar_ready;
    assign RVALID  = r_valid;
    assign RDATA   = r_data;
    assign RRESP   = r_resp;

    // a clear write zeroes exactly the selected bits at the accepting edge
    clear_bits_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (wr_now && hit_clr) |=> ((regs.out & $past(clr_mask)) == pin_clear_pkg::ALL_ZERO))
        else $error("clear write left a selected output bit set");

    // unselected bits hold across a clear write
    keep_others_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (wr_now && hit_clr) |=>
        ((regs.out & ~$past(clr_mask)) == ($past(regs.out) & ~$past(clr_mask))))
        else $error("clear write disturbed an unselected bit");

    // cleared general purpose output pins are low two edges later
    pin_low_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (wr_now && hit_clr) |-> ##2
        ((PIN_OUT & ~PIN_OE_N & $past(clr_mask, 2)) == pin_clear_pkg::ALL_ZERO))
        else $error("cleared output pin not driven low");

    // output enable follows function and direction
    oe_gpio_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        $rose(RST_N) or 1'b1 |=> (PIN_OE_N == ~$past(regs.func & regs.dir
                                              & pin_clear_pkg::IMPL_MASK)))
        else $error("pin enable does not match function and direction");

    // the alias reads as zero
    alias_read_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (ar_fire && rd_word == pin_clear_pkg::CLR_OFFSET) |=>
        (RVALID && RDATA == pin_clear_pkg::ALL_ZERO && RRESP == pin_clear_pkg::RESP_OKAY))
        else $error("clear alias read returned data");

    // mute and receive frame sync positions
    mute_map_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (wr_now && hit_clr && req.strb[3] && req.data[pin_clear_pkg::MUTE_BIT]
         && req.data[pin_clear_pkg::RX_FRAME_SYNC_BIT]) |=>
        (!regs.out[pin_clear_pkg::MUTE_BIT] && !regs.out[pin_clear_pkg::RX_FRAME_SYNC_BIT]))
        else $error("mute or frame sync bit not cleared");

    // serial data pin 0 maps to bit 0
    data_map_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (wr_now && hit_clr && req.strb[0] && req.data[pin_clear_pkg::SERIAL_DATA_LSB])
        |=> !regs.out[pin_clear_pkg::SERIAL_DATA_LSB])
        else $error("serial data bit not cleared");

    // reserved bits never hold a one
    reserved_zero_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        ((regs.out & pin_clear_pkg::RSVD_MASK) == pin_clear_pkg::ALL_ZERO)
        && ((RDATA & pin_clear_pkg::RSVD_MASK) == pin_clear_pkg::ALL_ZERO))
        else $error("reserved bit seen set");

    // response comes with the update, in the next cycle
    same_cycle_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (wr_now && hit_clr) |=> (BVALID && BRESP == pin_clear_pkg::RESP_OKAY
                                 && regs.out == $past(next_regs.out)))
        else $error("clear not applied with its response");

endmodule : pin_output_clear_alias

//--- testbench/pin_output_clear_alias_test.sv
`timescale 1ns/1ns
module pin_output_clear_alias_test;

    // one clear case: preset output data, clear word, strobes, expected data
    typedef struct packed {
        logic [31:0] pre;
        logic [31:0] clr;
        logic [3:0]  strb;
        logic [31:0] exp;
    } row_t;

    logic        CORE_CLK = 1'b0;
    logic        RST_N    = 1'b0;
    logic [7:0]  AWADDR   = 8'h00;
    logic        AWVALID  = 1'b0;
    logic        AWREADY;
    logic [31:0] WDATA    = 32'h0000_0000;
    logic [3:0]  WSTRB    = 4'h0;
    logic        WVALID   = 1'b0;
    logic        WREADY;
    logic [1:0]  BRESP;
    logic        BVALID;
    logic        BREADY   = 1'b0;
    logic [7:0]  ARADDR   = 8'h00;
    logic        ARVALID  = 1'b0;
    logic        ARREADY;
    logic [31:0] RDATA;
    logic [1:0]  RRESP;
    logic        RVALID;
    logic        RREADY   = 1'b0;
    logic [31:0] PIN_OUT;
    logic [31:0] PIN_OE_N;
    int          failures = 0;
    int          cmp_count = 0;
    logic [31:0] rd;
    logic [1:0]  rsp;
    row_t        rows [7];

    pin_output_clear_alias dut (
        .CORE_CLK(CORE_CLK), .RST_N(RST_N),
        .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
        .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
        .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
        .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
        .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
        .PIN_OUT(PIN_OUT), .PIN_OE_N(PIN_OE_N)
    );

    // 10 MHz core clock
    always #50 CORE_CLK = ~CORE_CLK;

    task automatic tally_and_finish;
        if (failures == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            failures++;
        end
    endtask : check

    // write with address and data offered together, wait for the response
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                             input logic [3:0] s, output logic [1:0] r);
        @(posedge CORE_CLK);
        AWADDR  <= a;
        WDATA   <= d;
        WSTRB   <= s;
        AWVALID <= 1'b1;
        WVALID  <= 1'b1;
        BREADY  <= 1'b1;
        // only the watchdog ends a wait for the response
        do begin
            @(posedge CORE_CLK);
            if (AWVALID && AWREADY) AWVALID <= 1'b0;
            if (WVALID && WREADY) WVALID <= 1'b0;
        end while (BVALID !== 1'b1);
        r = BRESP;
        BREADY <= 1'b0;
    endtask : axi_write

    // read one word, wait for the data
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        @(posedge CORE_CLK);
        ARADDR  <= a;
        ARVALID <= 1'b1;
        RREADY  <= 1'b1;
        // only the watchdog ends a wait for the data
        do begin
            @(posedge CORE_CLK);
            if (ARVALID && ARREADY) ARVALID <= 1'b0;
        end while (RVALID !== 1'b1);
        d = RDATA;
        r = RRESP;
        RREADY <= 1'b0;
    endtask : axi_read

    // watchdog well beyond the expected run length
    initial begin
        #(100 * 20000);
        failures++;
        tally_and_finish();
    end

    // main sequence
    initial begin
        rows[0] = {32'hFFFF_FFFF, 32'h8000_0000, 4'hF, 32'h7E00_FFFF};
        rows[1] = {32'hFFFF_FFFF, 32'h0000_0001, 4'hF, 32'hFE00_FFFE};
        rows[2] = {32'hFFFF_FFFF, 32'h0200_8000, 4'hF, 32'hFC00_7FFF};
        rows[3] = {32'h5A00_A5A5, 32'h0000_0000, 4'hF, 32'h5A00_A5A5};
        rows[4] = {32'hFFFF_FFFF, 32'h7C00_0F0F, 4'hF, 32'h8200_F0F0};
        rows[5] = {32'hFFFF_FFFF, 32'hFE00_FFFF, 4'hF, 32'h0000_0000};
        rows[6] = {32'hFFFF_FFFF, 32'hFE00_FFFF, 4'h1, 32'hFE00_FF00};
        repeat (16) @(posedge CORE_CLK);
        // outputs while held in reset
        check(PIN_OUT, pin_clear_pkg::ALL_ZERO);
        check(PIN_OE_N, pin_clear_pkg::ALL_ONES);
        check({31'h0, BVALID}, 32'h0000_0000);
        RST_N <= 1'b1;
        // table of clear cases, read back right after each clear
        for (int i = 0; i < 7; i++) begin
            axi_write(pin_clear_pkg::OUT_OFFSET, rows[i].pre, 4'hF, rsp);
            axi_write(pin_clear_pkg::CLR_OFFSET, rows[i].clr, rows[i].strb, rsp);
            check({30'h0, rsp}, {30'h0, pin_clear_pkg::RESP_OKAY});
            axi_read(pin_clear_pkg::OUT_OFFSET, rd, rsp);
            check(rd, rows[i].exp);
            check(PIN_OUT, rows[i].exp);
        end
        // clear alias reads zero, nothing stored there
        axi_read(pin_clear_pkg::CLR_OFFSET, rd, rsp);
        check(rd, pin_clear_pkg::ALL_ZERO);
        // general-purpose outputs on mute, rx frame sync and data 0
        axi_write(pin_clear_pkg::FUNC_OFFSET, pin_clear_pkg::ALL_ONES, 4'hF, rsp);
        axi_write(pin_clear_pkg::DIR_OFFSET, 32'h8200_0001, 4'hF, rsp);
        axi_write(pin_clear_pkg::OUT_OFFSET, pin_clear_pkg::ALL_ONES, 4'hF, rsp);
        axi_read(pin_clear_pkg::FUNC_OFFSET, rd, rsp);
        check(rd, pin_clear_pkg::IMPL_MASK);
        check(PIN_OE_N, 32'h7DFF_FFFE);
        check(PIN_OUT & 32'h8200_0001, 32'h8200_0001);
        axi_write(pin_clear_pkg::CLR_OFFSET, 32'h8000_0001, 4'hF, rsp);
        axi_read(pin_clear_pkg::DIR_OFFSET, rd, rsp);
        check(rd, 32'h8200_0001);
        check(PIN_OUT & 32'h8200_0001, 32'h0200_0000);
        check(PIN_OE_N, 32'h7DFF_FFFE);
        // unmapped address: refused, no effect
        axi_write(8'h40, pin_clear_pkg::ALL_ONES, 4'hF, rsp);
        check({30'h0, rsp}, {30'h0, pin_clear_pkg::RESP_SLVERR});
        axi_read(8'h40, rd, rsp);
        check(rd, pin_clear_pkg::ALL_ZERO);
        check({30'h0, rsp}, {30'h0, pin_clear_pkg::RESP_SLVERR});
        axi_read(pin_clear_pkg::OUT_OFFSET, rd, rsp);
        check(rd, 32'h7E00_FFFE);
        // second reset in mid-run returns output data and pins to zero and leaves every pin undriven
        @(posedge CORE_CLK);
        RST_N <= 1'b0;
        repeat (2) @(posedge CORE_CLK);
        RST_N <= 1'b1;
        @(posedge CORE_CLK);
        check(PIN_OUT, pin_clear_pkg::ALL_ZERO);
        check(PIN_OE_N, pin_clear_pkg::ALL_ONES);
        axi_read(pin_clear_pkg::OUT_OFFSET, rd, rsp);
        check(rd, pin_clear_pkg::ALL_ZERO);
        tally_and_finish();
    end

endmodule : pin_output_clear_alias_test
